// >>> design/mcbm_defs.vh
// Constants for the memory channel and bank mapper.
`ifndef MCBM_DEFS_VH
`define MCBM_DEFS_VH
`define MCBM_OFFSET_LSB    0
`define MCBM_OFFSET_W      8
`define MCBM_CHAN_LSB      8
`define MCBM_GRANULE_BYTES 256
`define MCBM_GRANULE_DW    64
`define MCBM_WAVE_ITEMS    64
`endif

// >>> design/mcbm_mapper.v
// Memory channel and bank mapper with work-group dispatch tracking.
`timescale 1ns/100ps
`include "mcbm_defs.vh"
module mcbm_mapper #(
  parameter NCU     = 4,
  parameter CHAN_W  = 3,
  parameter BANK_W  = 4,
  parameter ADDR_W  = 32,
  parameter WAVE_W  = 2,
  parameter GID_W   = 8
) (
  input  wire                    clock,
  input  wire                    rst_n,
  input  wire [NCU-1:0]          cuReqValid,
  input  wire [NCU*ADDR_W-1:0]   cuReqAddr,
  input  wire [NCU*WAVE_W-1:0]   cuReqWave,
  output reg  [NCU-1:0]          cuReqGrant,
  input  wire [(1<<CHAN_W)-1:0]  mcBusy,
  output reg  [(1<<CHAN_W)-1:0]  mcReqValid,
  output reg  [(1<<CHAN_W)*ADDR_W-1:0] mcReqAddr,
  output reg  [(1<<CHAN_W)*BANK_W-1:0] mcReqBank,
  output reg  [(1<<CHAN_W)*WAVE_W-1:0] mcReqWave,
  input  wire                    dispStart,
  input  wire [GID_W-1:0]        dispNumX,
  input  wire [GID_W-1:0]        dispNumY,
  input  wire [NCU-1:0]          cuGroupDone,
  output reg                     dispValid,
  output reg  [NCU-1:0]          dispCu,
  output reg  [2*GID_W-1:0]      dispIndex,
  output reg  [GID_W-1:0]        dispGroupX,
  output reg  [GID_W-1:0]        dispGroupY,
  output reg  [2*GID_W-1:0]      retireIndex,
  output reg                     retireValid,
  output reg                     dispIdle
);
  localparam NCH    = 1 << CHAN_W;
  localparam NBANK  = 1 << BANK_W;
  localparam BANK_LSB = `MCBM_CHAN_LSB + CHAN_W;
  localparam CUI_W  = (NCU > 1) ? $clog2(NCU) : 1;

  // Field extraction: offset bits never reach channel or bank select.
  function [CHAN_W-1:0] chanOf;
    input [ADDR_W-1:0] a;
    begin
      chanOf = a[`MCBM_CHAN_LSB +: CHAN_W];
    end
  endfunction

  function [BANK_W-1:0] bankOf;
    input [ADDR_W-1:0] a;
    begin
      bankOf = a[BANK_LSB +: BANK_W];
    end
  endfunction

  // One bit per channel and bank: set on a grant there, else cleared whenever that channel's mcBusy is low.
  reg  [NCH*NBANK-1:0] bankBusy_r;
  reg  [NCH*CUI_W-1:0] rrPtr_r;
  reg  [NCU-1:0]       grant;
  reg  [NCH-1:0]       chanHit;
  reg  [NCH*ADDR_W-1:0] chanAddr;
  reg  [NCH*BANK_W-1:0] chanBank;
  reg  [NCH*WAVE_W-1:0] chanWave;
  reg  [NCH*CUI_W-1:0]  rrPtr_nxt;
  reg  [NCH*NBANK-1:0]  bankBusy_nxt;
  reg  [CHAN_W-1:0]     ch;
  reg  [BANK_W-1:0]     bk;
  reg  [CUI_W-1:0]      idx;
  integer c;
  integer k;

  // Per-channel round-robin arbiter; each CU carries a single request,
  // so a grant is for one wavefront of that unit.
  always @*
  begin
    grant = {NCU{1'b0}};
    chanHit = {NCH{1'b0}};
    chanAddr = {NCH*ADDR_W{1'b0}};
    chanBank = {NCH*BANK_W{1'b0}};
    chanWave = {NCH*WAVE_W{1'b0}};
    rrPtr_nxt = rrPtr_r;
    bankBusy_nxt = bankBusy_r & ~{NCH*NBANK{1'b0}};
    ch = {CHAN_W{1'b0}};
    bk = {BANK_W{1'b0}};
    idx = {CUI_W{1'b0}};
    for (c = 0; c < NCH; c = c + 1)
    begin
      if (mcBusy[c] == 1'b0)
      begin
        bankBusy_nxt[c*NBANK +: NBANK] = {NBANK{1'b0}};
      end
    end
    for (c = 0; c < NCH; c = c + 1)
    begin
      for (k = 0; k < NCU; k = k + 1)
      begin
        idx = rrPtr_r[c*CUI_W +: CUI_W] + k[CUI_W-1:0];
        if (idx >= NCU)
        begin
          idx = idx - NCU[CUI_W-1:0];
        end
        ch = chanOf(cuReqAddr[idx*ADDR_W +: ADDR_W]);
        bk = bankOf(cuReqAddr[idx*ADDR_W +: ADDR_W]);
        // Same channel or same busy bank waits its turn.
        if (cuReqValid[idx] && !grant[idx] && ch == c[CHAN_W-1:0] &&
            !chanHit[c] && !mcBusy[c] &&
            !bankBusy_r[c*NBANK + bk])
        begin
          grant[idx] = 1'b1;
          chanHit[c] = 1'b1;
          chanAddr[c*ADDR_W +: ADDR_W] = cuReqAddr[idx*ADDR_W +: ADDR_W];
          chanBank[c*BANK_W +: BANK_W] = bk;
          chanWave[c*WAVE_W +: WAVE_W] =
            cuReqWave[idx*WAVE_W +: WAVE_W];
          bankBusy_nxt[c*NBANK + bk] = 1'b1;
          rrPtr_nxt[c*CUI_W +: CUI_W] =
            (idx == NCU - 1) ? {CUI_W{1'b0}} : idx + 1'b1;
        end
      end
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      cuReqGrant <= {NCU{1'b0}};
      mcReqValid <= {NCH{1'b0}};
      mcReqAddr  <= {NCH*ADDR_W{1'b0}};
      mcReqBank  <= {NCH*BANK_W{1'b0}};
      mcReqWave  <= {NCH*WAVE_W{1'b0}};
      bankBusy_r <= {NCH*NBANK{1'b0}};
      rrPtr_r    <= {NCH*CUI_W{1'b0}};
    end
    else
    begin
      cuReqGrant <= grant;
      mcReqValid <= chanHit;
      mcReqAddr  <= chanAddr;
      mcReqBank  <= chanBank;
      mcReqWave  <= chanWave;
      bankBusy_r <= bankBusy_nxt;
      rrPtr_r    <= rrPtr_nxt;
    end
  end

  // Dispatcher: linear order, one group per free CU, in-order retire.
  localparam ST_IDLE = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_DRAIN = 3'h4;
  reg  [2:0]        state_r;
  reg  [GID_W-1:0]  gx_r;
  reg  [GID_W-1:0]  gy_r;
  reg  [GID_W-1:0]  numX_r;
  reg  [GID_W-1:0]  numY_r;
  reg  [2*GID_W-1:0] nextIdx_r;
  reg  [2*GID_W-1:0] oldest_r;
  reg  [NCU-1:0]    cuBusy_r;
  reg  [NCU-1:0]    doneSeen_r;
  reg  [2*GID_W-1:0] cuIdx_r [0:NCU-1];
  reg  [NCU-1:0]    freeOne;
  reg  [NCU-1:0]    oldestCu;
  reg  [NCU-1:0]    retireMask;
  reg               lastGroup;
  integer u;

  always @*
  begin
    freeOne = {NCU{1'b0}};
    oldestCu = {NCU{1'b0}};
    for (u = NCU - 1; u >= 0; u = u - 1)
    begin
      if (!cuBusy_r[u])
      begin
        freeOne = {NCU{1'b0}};
        freeOne[u] = 1'b1;
      end
      if (cuBusy_r[u] && cuIdx_r[u] == oldest_r)
      begin
        oldestCu[u] = 1'b1;
      end
    end
    lastGroup = (gx_r == numX_r - 1'b1) && (gy_r == numY_r - 1'b1);
    // Retire and dispatch can fall in one cycle; both edit the busy mask,
    // so the dispatch update must fold the retire clear in or a unit hangs.
    retireMask = (|(oldestCu & (doneSeen_r | cuGroupDone))) ? oldestCu :
                 {NCU{1'b0}};
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      gx_r <= {GID_W{1'b0}};
      gy_r <= {GID_W{1'b0}};
      numX_r <= {GID_W{1'b0}};
      numY_r <= {GID_W{1'b0}};
      nextIdx_r <= {2*GID_W{1'b0}};
      oldest_r <= {2*GID_W{1'b0}};
      cuBusy_r <= {NCU{1'b0}};
      doneSeen_r <= {NCU{1'b0}};
      dispValid <= 1'b0;
      dispCu <= {NCU{1'b0}};
      dispIndex <= {2*GID_W{1'b0}};
      dispGroupX <= {GID_W{1'b0}};
      dispGroupY <= {GID_W{1'b0}};
      retireIndex <= {2*GID_W{1'b0}};
      retireValid <= 1'b0;
      dispIdle <= 1'b1;
    end
    else
    begin
      dispValid <= 1'b0;
      retireValid <= 1'b0;
      // A finished group that is not the oldest holds its CU until
      // every older group has retired.
      doneSeen_r <= (doneSeen_r | (cuGroupDone & cuBusy_r));
      if (|retireMask)
      begin
        cuBusy_r <= cuBusy_r & ~oldestCu;
        doneSeen_r <= (doneSeen_r | cuGroupDone) & ~oldestCu;
        retireIndex <= oldest_r;
        retireValid <= 1'b1;
        oldest_r <= oldest_r + 1'b1;
      end
      case (state_r)
        ST_IDLE:
        begin
          dispIdle <= 1'b1;
          if (dispStart && dispNumX != 0 && dispNumY != 0)
          begin
            numX_r <= dispNumX;
            numY_r <= dispNumY;
            gx_r <= {GID_W{1'b0}};
            gy_r <= {GID_W{1'b0}};
            nextIdx_r <= {2*GID_W{1'b0}};
            oldest_r <= {2*GID_W{1'b0}};
            dispIdle <= 1'b0;
            state_r <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (|freeOne)
          begin
            dispValid <= 1'b1;
            dispCu <= freeOne;
            dispIndex <= nextIdx_r;
            dispGroupX <= gx_r;
            dispGroupY <= gy_r;
            nextIdx_r <= nextIdx_r + 1'b1;
            cuBusy_r <= (cuBusy_r & ~retireMask) | freeOne;
            if (lastGroup)
            begin
              state_r <= ST_DRAIN;
            end
            else if (gx_r == numX_r - 1'b1)
            begin
              gx_r <= {GID_W{1'b0}};
              gy_r <= gy_r + 1'b1;
            end
            else
            begin
              gx_r <= gx_r + 1'b1;
            end
          end
        end
        ST_DRAIN:
        begin
          if (cuBusy_r == {NCU{1'b0}})
          begin
            dispIdle <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCU; g = g + 1)
    begin : gTag
      always @(posedge clock)
      begin
        if (!rst_n)
        begin
          cuIdx_r[g] <= {2*GID_W{1'b0}};
        end
        else if (state_r == ST_RUN && freeOne[g])
        begin
          cuIdx_r[g] <= nextIdx_r;
        end
      end
    end
  endgenerate
endmodule

// >>> dv/mcbm_asserts.sv
// Assertion checker for the memory channel and bank mapper.
`timescale 1ns/100ps
module mcbm_asserts #(parameter NCU = 4, CHAN_W = 3, BANK_W = 4,
  ADDR_W = 32, GID_W = 8) (
  input logic                          clock,
  input logic                          rst_n,
  input logic [NCU-1:0]                cuReqGrant,
  input logic [(1<<CHAN_W)-1:0]        mcBusy,
  input logic [(1<<CHAN_W)-1:0]        mcReqValid,
  input logic [(1<<CHAN_W)*ADDR_W-1:0] mcReqAddr,
  input logic [(1<<CHAN_W)*BANK_W-1:0] mcReqBank,
  input logic                          dispStart,
  input logic [GID_W-1:0]              dispNumX,
  input logic                          dispValid,
  input logic [2*GID_W-1:0]            dispIndex,
  input logic [GID_W-1:0]              dispGroupX,
  input logic [GID_W-1:0]              dispGroupY,
  input logic [2*GID_W-1:0]            retireIndex,
  input logic                          retireValid,
  input logic                          dispIdle
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [2*GID_W-1:0] nextRet_r;
  // Retire numbering restarts with every grid, as dispatch numbering does.
  always @(posedge clock)
    if (!rst_n || (dispStart && dispIdle))
      nextRet_r <= '0;
    else if (retireValid)
      nextRet_r <= nextRet_r + 1'b1;
  for (genvar c = 0; c < (1 << CHAN_W); c++)
  begin : g_ch
    property p_ch;
      mcReqValid[c] |-> mcReqAddr[c*ADDR_W+8 +: CHAN_W] == c;
    endproperty
    property p_bk;
      mcReqValid[c] |-> mcReqBank[c*BANK_W +: BANK_W] ==
        mcReqAddr[c*ADDR_W+8+CHAN_W +: BANK_W];
    endproperty
    property p_bsy;
      mcBusy[c] |=> !mcReqValid[c];
    endproperty
    a_ch: assert property (p_ch) else $error("channel field wrong");
    a_bk: assert property (p_bk) else $error("bank field wrong");
    a_bsy: assert property (p_bsy) else $error("busy chan issued");
  end
  property p_pr;
    $countones(cuReqGrant) == $countones(mcReqValid);
  endproperty
  property p_ix;
    dispValid |-> dispIndex == dispGroupX + dispGroupY * dispNumX;
  endproperty
  property p_gx;
    dispValid |-> dispGroupX < dispNumX;
  endproperty
  property p_rt;
    retireValid |-> retireIndex == nextRet_r;
  endproperty
  property p_id;
    dispValid |-> !dispIdle;
  endproperty
  a_pr: assert property (p_pr) else $error("grant count wrong");
  a_ix: assert property (p_ix) else $error("dispatch index wrong");
  a_gx: assert property (p_gx) else $error("group x too large");
  a_rt: assert property (p_rt) else $error("retire out of order");
  a_id: assert property (p_id) else $error("dispatch while idle");
  c_gr: cover property (&cuReqGrant[1:0]);
  c_dv: cover property (dispValid);
  c_rv: cover property (retireValid);
endmodule
bind mcbm_mapper mcbm_asserts #(.NCU(NCU), .CHAN_W(CHAN_W), .BANK_W(BANK_W),
  .ADDR_W(ADDR_W), .GID_W(GID_W)) mcbm_asserts_i (.*);

// >>> dv/mcbm_mc_model.sv
// Per-channel memory controller model that stalls after each request.
`timescale 1ns/100ps
module mcbm_mc_model #(parameter NCH = 8) (
  input  logic           clock,
  input  logic           rst_n,
  input  logic [NCH-1:0] mcReqValid,
  input  logic [3:0]     holdCycles,
  output logic [NCH-1:0] mcBusy
);
  logic [3:0] cnt_r [NCH];
  // A hold of zero answers promptly; larger holds model a slow controller.
  always @(posedge clock)
    for (int i = 0; i < NCH; i++)
      if (!rst_n)
        cnt_r[i] <= '0;
      else if (mcReqValid[i])
        cnt_r[i] <= holdCycles;
      else if (cnt_r[i] != 0)
        cnt_r[i] <= cnt_r[i] - 1'b1;
  always_comb
    for (int i = 0; i < NCH; i++)
      mcBusy[i] = cnt_r[i] != 0;
endmodule

// >>> dv/tb_top.sv
// Self-checking testbench for the memory channel and bank mapper.
`timescale 1ns/100ps
module tb_top;
  logic         clock = 0, rst_n = 0, dispStart = 0;
  logic [3:0]   cuReqValid = 0, cuGroupDone = 0, holdCycles = 0;
  logic [127:0] cuReqAddr = 0;
  logic [7:0]   cuReqWave = 0, dispNumX = 1, dispNumY = 1;
  logic [3:0]   cuReqGrant, dispCu;
  logic [7:0]   mcBusy, mcReqValid, dispGroupX, dispGroupY;
  logic [255:0] mcReqAddr;
  logic [31:0]  mcReqBank;
  logic [15:0]  mcReqWave, dispIndex, retireIndex;
  logic         dispValid, retireValid, dispIdle;
  integer       seed = 32'h48a0534e, errors = 0, num_checks = 0;
  int           timer[4];
  logic [37:0]  mcQ[8][$];
  logic [31:0]  dispQ[$];
  logic [15:0]  retQ[$];
  mcbm_mapper   mcbm_mapper_i (
    .clock       (clock),
    .rst_n       (rst_n),
    .cuReqValid  (cuReqValid),
    .cuReqAddr   (cuReqAddr),
    .cuReqWave   (cuReqWave),
    .cuReqGrant  (cuReqGrant),
    .mcBusy      (mcBusy),
    .mcReqValid  (mcReqValid),
    .mcReqAddr   (mcReqAddr),
    .mcReqBank   (mcReqBank),
    .mcReqWave   (mcReqWave),
    .dispStart   (dispStart),
    .dispNumX    (dispNumX),
    .dispNumY    (dispNumY),
    .cuGroupDone (cuGroupDone),
    .dispValid   (dispValid),
    .dispCu      (dispCu),
    .dispIndex   (dispIndex),
    .dispGroupX  (dispGroupX),
    .dispGroupY  (dispGroupY),
    .retireIndex (retireIndex),
    .retireValid (retireValid),
    .dispIdle    (dispIdle)
  );
  mcbm_mc_model mcbm_mc_model_i (
    .clock      (clock),
    .rst_n      (rst_n),
    .mcReqValid (mcReqValid),
    .holdCycles (holdCycles),
    .mcBusy     (mcBusy)
  );
  initial
    forever #2.5 clock = ~clock;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic waitOut(input int n, input int lim);
    if (n >= lim)
    begin
      errors++;
      stop_test;
    end
  endtask
  // Requests are held until granted; expectations go in the queue in the
  // order the round-robin arbiter should grant them.
  task automatic memReq(input logic [3:0] m, input logic [127:0] a,
                        input int first);
    int i;
    int n;
    @(negedge clock);
    for (int k = 0; k < 4; k++)
    begin
      i = (first + k) % 4;
      cuReqWave[2*i+:2] = 2'(i);
      if (m[i])
        mcQ[a[32*i+8+:3]].push_back({2'(i), a[32*i+11+:4], a[32*i+:32]});
    end
    cuReqAddr = a;
    cuReqValid = m;
    for (n = 0; cuReqValid != 0 && n < 100; n++)
    begin
      @(negedge clock);
      cuReqValid = cuReqValid & ~cuReqGrant;
    end
    waitOut(n, 100);
  endtask
  task automatic grid(input int nx, input int ny);
    int n;
    for (int k = 0; k < nx * ny; k++)
    begin
      dispQ.push_back({8'(k / nx), 8'(k % nx), 16'(k)});
      retQ.push_back(16'(k));
    end
    @(negedge clock);
    dispNumX = 8'(nx);
    dispNumY = 8'(ny);
    dispStart = 1;
    @(negedge clock);
    dispStart = 0;
    for (n = 0; (!dispIdle || n < 3) && n < 500; n++)
      @(negedge clock);
    waitOut(n, 500);
    chk(dispQ.size() + retQ.size(), 0);
    $display("grid %0d by %0d done", nx, ny);
  endtask
  always @(negedge clock)
    if (rst_n)
    begin
      logic [37:0] got;
      for (int c = 0; c < 8; c++)
        if (mcReqValid[c])
        begin
          got = {mcReqWave[2*c+:2], mcReqBank[4*c+:4], mcReqAddr[32*c+:32]};
          chk(got, mcQ[c].pop_front());
        end
      if (dispValid)
        chk({dispGroupY, dispGroupX, dispIndex}, dispQ.pop_front());
      if (retireValid)
        chk(retireIndex, retQ.pop_front());
      for (int i = 0; i < 4; i++)
      begin
        cuGroupDone[i] <= timer[i] == 1;
        if (timer[i] > 0)
          timer[i]--;
        if (dispValid && dispCu[i])
        begin
          chk(timer[i], 0);
          timer[i] = 3 + ($random(seed) & 7);
        end
      end
    end
  initial
  begin
    logic [31:0]  r;
    logic [127:0] a;
    repeat (4) @(negedge clock);
    rst_n = 1;
    chk(dispIdle, 1);
    for (int c = 0; c < 8; c++)
    begin
      r = $random(seed);
      r[10:8] = 3'(c);
      memReq(4'h1, {96'h0, r}, 0);
    end
    $display("channel sweep done");
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      r[10:8] = 3'(i);
      a[32*i+:32] = r;
    end
    memReq(4'hf, a, 0);
    $display("parallel issue done");
    holdCycles = 4'h3;
    r[10:8] = 3'h7;
    memReq(4'hf, {4{r}}, 1);
    $display("conflict issue done");
    grid(3, 2);
    grid(1, 5);
    for (int c = 0; c < 8; c++)
      chk(mcQ[c].size(), 0);
    stop_test;
  end
endmodule
